// ### cie_clear_exec.v
// Decode and execution of the register-clear and watchdog-clear instructions
//
// Summary of operation
// - Access bit zero uses access bank unless indexed
// - Access bit one uses bank select register
// - Destination bit picks working or file register
// - Three-bit field selects bit zero to seven
// - Register clear writes zero, sets zero flag
// - Extended set, access zero, low address: indexed
// - Register clear: one word, four phases
// - Watchdog clear zeroes counter and postscaler
// - Watchdog clear sets time-out and power-down bits
//
// One instruction cycle is walked as four phases after the decode edge:
// read, process and write follow on the next three clocks, and the block
// is idle again once the write phase has been issued.
// Watchdog effects are applied on the decode edge itself, so the counter,
// postscaler and both status bits are settled on the same edge that takes the
// word, well inside the cycle.
// Limitation: the fetch stage must not offer a word while busy is high;
// such a word is ignored rather than queued, since there is no buffer.
//
`timescale 1ns/100ps
`include "cie_defines.vh"
module cie_clear_exec
#(
  parameter WDOG_W = 8,   // Watchdog counter width
  parameter POST_W = 7    // Postscaler width
)
(
  input  wire              i_clock,
  input  wire              i_rst,
  input  wire              i_opcode_valid,          // Fetch presents a new opcode, pulse at cycle start
  input  wire [15:0]       i_opcode,
  input  wire [3:0]        i_bank_select_register,
  input  wire              i_ext_enable,
  input  wire [11:0]       i_index_base,
  input  wire [7:0]        i_file_rdata,            // Data read in the read phase
  input  wire              i_wdog_tick,             // Watchdog time base, same clock
  output reg  [11:0]       o_file_addr,
  output reg               o_file_rd,
  output reg               o_file_we,
  output reg  [7:0]        o_file_wdata,
  output reg  [7:0]        o_working_register,
  output reg               o_zero_flag,
  output reg  [WDOG_W-1:0] o_watchdog_counter,
  output reg  [POST_W-1:0] o_wdog_postscaler,
  output reg               o_timeout_status_bit,
  output reg               o_powerdown_status_bit,
  output reg               o_indexed_mode,
  output reg  [7:0]        o_bit_mask,              // One-hot mask of the bit operand
  output reg  [1:0]        o_phase,
  output reg               o_busy
);
  // Two-state sequencer; the phase register counts inside the busy state
  localparam ST_IDLE = 1'b0;  // Waiting for an opcode
  localparam ST_EXEC = 1'b1;  // Walking the read, process and write phases

  reg        state;           // Sequencer state
  reg [15:0] opcode;          // Held opcode for the cycle
  reg        is_clr;          // Held register-clear decode
  wire [11:0] gen_addr;       // Formed data address
  wire        gen_indexed;    // Indexed literal offset in use

  // Decoders, each called from one place
  function is_clrreg;
    input [15:0] op;
    begin
      is_clrreg = (op[`CIE_CLRREG_OP_MSB:`CIE_CLRREG_OP_LSB] == `CIE_CLRREG_OP);
    end
  endfunction

  // Watchdog clear is one fixed word, all sixteen bits compared
  function is_wdclr;
    input [15:0] op;
    begin
      is_wdclr = (op == `CIE_WDCLR_OP);
    end
  endfunction

  // One-hot bit position from a three-bit field
  function [7:0] bit_decode;
    input [2:0] pos;
    begin
      bit_decode = 8'h01 << pos;
    end
  endfunction

  // Address former shared with other byte-oriented operations
  // Combinational, so the address follows the held opcode
  cie_addr_gen u_addr
  (
    .i_bank_select_register (i_bank_select_register),
    .i_access_bit           (opcode[`CIE_ACCESS_BIT]),
    .i_ext_enable           (i_ext_enable),
    .i_faddr                (opcode[`CIE_FADDR_MSB:`CIE_FADDR_LSB]),
    .i_index_base           (i_index_base),
    .o_addr                 (gen_addr),
    .o_indexed              (gen_indexed)
  );

  // Phase sequencer and register-clear datapath
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state              <= ST_IDLE;
      opcode             <= 16'h0000;
      is_clr             <= 1'b0;
      o_phase            <= `CIE_PH_DECODE;
      o_busy             <= 1'b0;
      o_file_addr        <= 12'h000;
      o_file_rd          <= 1'b0;
      o_file_we          <= 1'b0;
      o_file_wdata       <= 8'h00;
      o_working_register <= 8'h00;
      o_zero_flag        <= 1'b0;
      o_indexed_mode     <= 1'b0;
      o_bit_mask         <= 8'h00;
    end
    else
    begin
      o_file_rd <= 1'b0;
      o_file_we <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (i_opcode_valid)
          begin
            // Decode phase: latch opcode, start one instruction cycle
            // Bit mask is formed for every word; only bit-oriented ops use it
            opcode     <= i_opcode;
            is_clr     <= is_clrreg(i_opcode);
            o_bit_mask <= bit_decode(i_opcode[`CIE_BITADDR_MSB:`CIE_BITADDR_LSB]);
            o_phase    <= `CIE_PH_READ;
            o_busy     <= 1'b1;
            state      <= ST_EXEC;
          end
        end
        ST_EXEC:
        begin
          case (o_phase)
            `CIE_PH_READ:
            begin
              // Read the addressed register, value unused by a clear
              // Bank select and index base are taken on this clock, one after decode
              o_file_addr    <= gen_addr;
              o_indexed_mode <= is_clr & gen_indexed;
              o_file_rd      <= is_clr;
              o_phase        <= `CIE_PH_PROCESS;
            end
            `CIE_PH_PROCESS:
            begin
              // Result is the constant zero; zero flag only
              if (is_clr)
              begin
                o_file_wdata <= 8'h00;
                o_zero_flag  <= 1'b1;
              end
              o_phase <= `CIE_PH_WRITE;
            end
            `CIE_PH_WRITE:
            begin
              // Write back of the zero result
              // Destination bit steers: one to the file register, zero to working
              // A clear word carries a one in that position, so it lands in the file
              if (is_clr && opcode[`CIE_DEST_BIT])
                o_file_we <= 1'b1;
              else if (is_clr)
                o_working_register <= o_file_wdata;
              o_phase <= `CIE_PH_DECODE;
              o_busy  <= 1'b0;
              state   <= ST_IDLE;
            end
            default:
            begin
              o_phase <= `CIE_PH_DECODE;
              state   <= ST_IDLE;
            end
          endcase
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Watchdog counter, postscaler and reset-cause bits
  // Clear acts on decode so all effects land inside the one cycle
  // A time-out leaves its mark in the status bit until the next watchdog
  // clear, so software can tell a time-out from an orderly restart
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Both reset-cause bits read one after a reset
      o_watchdog_counter     <= {WDOG_W{1'b0}};
      o_wdog_postscaler      <= {POST_W{1'b0}};
      o_timeout_status_bit   <= 1'b1;
      o_powerdown_status_bit <= 1'b1;
    end
    else if (state == ST_IDLE && i_opcode_valid && is_wdclr(i_opcode))
    begin
      // Clear wins over a coincident tick
      // Zero flag and the other status are left alone here
      o_watchdog_counter     <= {WDOG_W{1'b0}};
      o_wdog_postscaler      <= {POST_W{1'b0}};
      o_timeout_status_bit   <= 1'b1;
      o_powerdown_status_bit <= 1'b1;
    end
    else if (i_wdog_tick)
    begin
      // Postscaler rolls over into the counter; time-out clears the bit
      o_wdog_postscaler <= o_wdog_postscaler + {{(POST_W-1){1'b0}}, 1'b1};
      if (&o_wdog_postscaler)
      begin
        // Counter wraps and keeps running after a time-out
        o_watchdog_counter <= o_watchdog_counter + {{(WDOG_W-1){1'b0}}, 1'b1};
        if (&o_watchdog_counter)
          o_timeout_status_bit <= 1'b0;
      end
    end
  end
endmodule

// ### cie_defines.vh
// Constants for the clear-instruction decode and execute block
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH
// Register-clear opcode: upper seven bits 0110 101
`define CIE_CLRREG_OP      7'h35
`define CIE_CLRREG_OP_MSB  15
`define CIE_CLRREG_OP_LSB  9
// Field positions inside the 16-bit opcode
`define CIE_ACCESS_BIT     8
`define CIE_DEST_BIT       9
`define CIE_BITADDR_MSB    11
`define CIE_BITADDR_LSB    9
`define CIE_FADDR_MSB      7
`define CIE_FADDR_LSB      0
// Watchdog-clear opcode
`define CIE_WDCLR_OP       16'h0004
// Indexed literal offset limit (f below this value)
`define CIE_INDEX_LIMIT    8'h5f
// Access bank number used when the access bit is zero
`define CIE_ACCESS_BANK    4'h0
// Phase codes within one instruction cycle
`define CIE_PH_DECODE      2'h0
`define CIE_PH_READ        2'h1
`define CIE_PH_PROCESS     2'h2
`define CIE_PH_WRITE       2'h3
// Reset values
`define CIE_WDOG_RST       8'h00
`define CIE_POST_RST       7'h00
`endif

// ### cie_addr_gen.v
// Data memory address former for file-register operands
`timescale 1ns/100ps
`include "cie_defines.vh"
module cie_addr_gen
(
  input  wire [3:0]  i_bank_select_register,
  input  wire        i_access_bit,
  input  wire        i_ext_enable,
  input  wire [7:0]  i_faddr,
  input  wire [11:0] i_index_base,
  output reg  [11:0] o_addr,
  output reg         o_indexed
);
  // Bank formation, indexed mode takes priority in the access bank
  always @*
  begin
    o_indexed = 1'b0;
    if (!i_access_bit && i_ext_enable && (i_faddr < `CIE_INDEX_LIMIT))
    begin
      // Literal offset added to the index pointer
      o_indexed = 1'b1;
      o_addr    = i_index_base + {4'h0, i_faddr};
    end
    else if (!i_access_bit)
    begin
      // Fixed access bank, bank select ignored
      o_addr = {`CIE_ACCESS_BANK, i_faddr};
    end
    else
    begin
      // Bank taken from the bank select register
      o_addr = {i_bank_select_register, i_faddr};
    end
  end
endmodule

// ### cie_fetch_model.sv
// Behavioural fetch stage that hands opcode words to the clear block
`timescale 1ns/100ps
module cie_fetch_model
(
  input  wire        i_clock,
  input  wire        i_busy,
  output reg         o_opcode_valid,
  output reg  [15:0] o_opcode
);
  initial o_opcode_valid = 1'b0;
  initial o_opcode = 16'h0000;
  // Wait for an idle block, then offer one word for one cycle
  task issue(input [15:0] op);
    begin
      @(posedge i_clock);
      while (i_busy)
        @(posedge i_clock);
      o_opcode_valid <= 1'b1;
      o_opcode       <= op;
      @(posedge i_clock);
      o_opcode_valid <= 1'b0;
      o_opcode       <= ~op;  // Stale word must not look valid
    end
  endtask
endmodule

// ### cie_clear_exec_asserts.sv
// Concurrent checks on the clear-instruction block ports
`timescale 1ns/100ps
`include "cie_defines.vh"
module cie_clear_exec_asserts #(parameter WDOG_W = 8, parameter POST_W = 7)
(
  input wire i_clock, i_rst, i_opcode_valid, i_ext_enable, o_file_rd, o_file_we, o_zero_flag, o_busy,
  input wire o_timeout_status_bit, o_powerdown_status_bit, o_indexed_mode,
  input wire [15:0] i_opcode,
  input wire [3:0] i_bank_select_register,
  input wire [11:0] i_index_base, o_file_addr,
  input wire [7:0] o_file_wdata, o_bit_mask,
  input wire [WDOG_W-1:0] o_watchdog_counter,
  input wire [POST_W-1:0] o_wdog_postscaler
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Accepted words of each kind
  wire take = i_opcode_valid && !o_busy;
  wire wdc  = take && i_opcode == `CIE_WDCLR_OP;
  wire clr  = take && i_opcode[15:9] == `CIE_CLRREG_OP;
  wire low  = i_ext_enable && i_opcode[7:0] < 8'h5f;
  a_wdog_zeroed: assert property (wdc |=> o_watchdog_counter == 0 && o_wdog_postscaler == 0)
    else $error("watchdog not cleared");
  a_wdog_status: assert property (wdc |=>
    o_timeout_status_bit && o_powerdown_status_bit && $stable(o_zero_flag))
    else $error("status bits wrong after watchdog clear");
  a_clr_phases: assert property (clr |-> ##2 o_file_rd ##2 o_file_we && !o_busy)
    else $error("clear phases out of order");
  a_clr_result: assert property (clr |-> ##3 o_zero_flag && o_file_wdata == 8'h00)
    else $error("clear result wrong");
  a_access_bank: assert property (clr && !i_opcode[8] && !low |->
    ##2 !o_indexed_mode && o_file_addr == {4'h0, $past(i_opcode[7:0], 2)})
    else $error("access bank address wrong");
  a_bank_select: assert property (clr && i_opcode[8] |->
    ##2 o_file_addr == {$past(i_bank_select_register), $past(i_opcode[7:0], 2)})
    else $error("banked address wrong");
  a_indexed_mode: assert property (clr && !i_opcode[8] && low |->
    ##2 o_indexed_mode && o_file_addr == $past(i_index_base) + {4'h0, $past(i_opcode[7:0], 2)})
    else $error("indexed address wrong");
  a_dest_file: assert property (clr && i_opcode[9] |-> ##4 o_file_we)
    else $error("result not written to the file register");
  a_bit_select: assert property (take |=> o_bit_mask == 8'h01 << $past(i_opcode[11:9]))
    else $error("bit mask wrong");
  // Main scenarios reached
  c_wdog: cover property (wdc);
  c_banked: cover property (clr && i_opcode[8]);
  c_indexed: cover property (clr && !i_opcode[8] && low);
endmodule
bind cie_clear_exec cie_clear_exec_asserts #(.WDOG_W(WDOG_W), .POST_W(POST_W)) u_chk (.i_clock, .i_rst,
  .i_opcode_valid, .i_ext_enable, .o_file_rd, .o_file_we, .o_zero_flag, .o_busy, .o_timeout_status_bit,
  .o_powerdown_status_bit, .o_indexed_mode, .i_opcode, .i_bank_select_register, .i_index_base, .o_file_addr,
  .o_file_wdata, .o_bit_mask, .o_watchdog_counter, .o_wdog_postscaler);

// ### tb.sv
// Self-checking testbench for the clear-instruction block
`timescale 1ns/100ps
`include "cie_defines.vh"
module tb;
  localparam  TB_WDOG_W = 3;  // Narrow watchdog so a time-out comes within a short run
  localparam  TB_POST_W = 2;  // Narrow postscaler for the same reason
  reg         i_clock, i_rst, i_ext_enable, i_wdog_tick, tick_on;
  reg  [3:0]  i_bank_select_register;
  reg  [11:0] i_index_base;
  wire        i_opcode_valid, o_file_rd, o_file_we, o_zero_flag, o_timeout_status_bit, o_powerdown_status_bit;
  wire        o_indexed_mode, o_busy;
  wire [15:0] i_opcode;
  wire [11:0] o_file_addr;
  wire [7:0]  o_file_wdata, o_working_register, o_bit_mask;
  wire [TB_WDOG_W-1:0] o_watchdog_counter;
  wire [TB_POST_W-1:0] o_wdog_postscaler;
  wire [1:0]  o_phase;
  integer     failures, samples_checked;
  cie_fetch_model fetch (.i_clock(i_clock), .i_busy(o_busy), .o_opcode_valid(i_opcode_valid), .o_opcode(i_opcode));
  cie_clear_exec #(.WDOG_W(TB_WDOG_W), .POST_W(TB_POST_W)) DUT (.i_clock, .i_rst, .i_opcode_valid, .i_opcode,
    .i_bank_select_register, .i_ext_enable,
    .i_index_base, .i_file_rdata(8'h00), .i_wdog_tick, .o_file_addr, .o_file_rd, .o_file_we, .o_file_wdata,
    .o_working_register, .o_zero_flag, .o_watchdog_counter, .o_wdog_postscaler, .o_timeout_status_bit,
    .o_powerdown_status_bit, .o_indexed_mode, .o_bit_mask, .o_phase, .o_busy);
  // Compare and count
  task check(input [15:0] seen, input [15:0] exp, input [8*8:1] name);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // One register clear, each output looked at in its own cycle
  task run_clr(input a, input [7:0] f, input ext, input [11:0] addr, input idx);
    begin
      @(posedge i_clock);
      i_ext_enable <= ext;
      fetch.issue({`CIE_CLRREG_OP, a, f});
      @(posedge i_clock);
      #1 check(o_file_addr, addr, "address");
      check(o_indexed_mode, idx, "indexed");
      check(o_file_rd, 1, "read");
      check(o_phase, `CIE_PH_PROCESS, "phase");
      @(posedge i_clock);
      #1 check(o_zero_flag, 1, "zero");
      check(o_file_wdata, 0, "wdata");
      @(posedge i_clock);
      #1 check(o_file_we, 1, "write");
      check(o_busy, 0, "busy");
      check(o_bit_mask, 8'h20, "mask");
      check(o_phase, `CIE_PH_DECODE, "phase");
      check(o_working_register, 8'h00, "working");
      $display("test done: clear of %h", f);
    end
  endtask
  // Verdict and end of run
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Free-running clock, 8 ns
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Watchdog time base pulses while enabled
  always @(posedge i_clock)
    i_wdog_tick <= tick_on & ~i_wdog_tick;
  // Hang guard, far beyond the hundred or so cycles needed
  initial
  begin
    #20000;
    failures = failures + 1;
    conclude;
  end
  // Main sequence
  initial
  begin
    failures = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    i_ext_enable = 1'b0;
    tick_on = 1'b0;
    i_bank_select_register = 4'h5;
    i_index_base = 12'h300;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    tick_on <= 1'b1;
    #1 check(o_zero_flag, 0, "zero");
    run_clr(1'b1, 8'h5a, 1'b0, 12'h55a, 1'b0);
    run_clr(1'b0, 8'ha0, 1'b0, 12'h0a0, 1'b0);
    run_clr(1'b0, 8'h10, 1'b1, 12'h310, 1'b1);
    run_clr(1'b0, 8'h5f, 1'b1, 12'h05f, 1'b0);
    // Run the watchdog into a time-out and on until the counter is non-zero
    @(posedge i_clock);
    while (o_timeout_status_bit || o_watchdog_counter == 0)
      @(posedge i_clock);
    tick_on <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 check(o_timeout_status_bit, 0, "timeout");
    check(|o_watchdog_counter, 1, "counter");
    fetch.issue(`CIE_WDCLR_OP);
    #1 check(o_watchdog_counter, 0, "counter");
    check(o_wdog_postscaler, 0, "postscal");
    check(o_timeout_status_bit, 1, "timeout");
    check(o_powerdown_status_bit, 1, "powerdn");
    check(o_zero_flag, 1, "zero");
    $display("test done: watchdog clear");
    conclude;
  end
endmodule
